/* File: src/mem_space_params.svh */
// constants for the memory space decoder
`ifndef MEM_SPACE_PARAMS_SVH
`define MEM_SPACE_PARAMS_SVH
`define FLASH_END_16K       16'h3FFF
`define FLASH_END_8K        16'h1FFF
`define LOCK_BYTE_16K       16'h3BFF
`define LOCK_BYTE_8K        16'h1FFF
`define LOWER_RAM_TOP       8'h7F
`define BIT_AREA_BASE       8'h20
`define BIT_AREA_LAST       8'h2F
`define STACK_PTR_RESET     8'h07
`define STATUS_BANK_LSB     3
`define PAGE_SEL_ADDR       8'hAA
`define DP_UPPER_ADDR       8'h83
`define DP_LOWER_ADDR       8'h82
`define STACK_PTR_ADDR      8'h81
`define STATUS_WORD_ADDR    8'hD0
`define SFR_PAGE_ZERO       8'h00
`define PAGE_SEL_RESET      8'h00
`define ONCHIP_EXTERNAL_RAM_ADDR_BITS      10
`endif

/* File: src/mem_space_pkg.sv */
// types for the memory space decoder
`default_nettype none
package mem_space_pkg;
  typedef enum logic [2:0] {
    DS_NONE = 3'b001,
    DS_RAM  = 3'b010,
    DS_SFR  = 3'b100
  } data_sel_t;

  typedef enum logic [2:0] {
    CS_FLASH    = 3'b001,
    CS_LOCK     = 3'b010,
    CS_RESERVED = 3'b100
  } code_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       indirect;
    logic       bit_op;
    logic       write;
    logic [7:0] wdata;
  } iram_req_t;

  typedef struct packed {
    logic       use_data_pointer;
    logic       write;
    logic [7:0] wdata;
  } xdata_req_t;
endpackage : mem_space_pkg
`default_nettype wire

/* File: src/cpu_memory_space_decoder.sv */
// address decoder for program, internal ram and external-data spaces
//
// Behaviour
// - flash spans zero to 0x3FFF or 0x1FFF inside 64 kB space
// - lock byte sits at 0x3BFF on 16 kB, 0x1FFF on 8 kB
// - on 16 kB parts addresses above lock byte decode as reserved
// - code reads go to flash; enabled external writes steer to flash
// - by default external moves reach on-chip external ram
// - lower 128 bytes reachable by direct and indirect modes
// - above 0x7F direct hits special registers, indirect upper ram
// - 0x00..0x1F are four banks of eight, status bits 3,4 select
// - bank 0..3 map to 0x00, 0x08, 0x10, 0x18 bases
// - indirect pointers come from index reg 0 or 1 of active bank
// - bytes 0x20..0x2F bit addressable, bit addr 8*offset+bit
// - bit or byte access chosen by operand type, not address
// - push writes stack pointer plus one; pointer increments on the same edge
// - reset loads stack pointer with 0x07
// - stack may sit anywhere and span the full 256 bytes
// - one kilobyte on-chip ram lives in external-data space
// - 16-bit external move uses full data pointer as address
// - data pointer is two byte registers, upper and lower
// - 8-bit external move uses page select high, index reg low
// - page select is rw 0xAA page 0, reset zero
// - direct 0x80..0xFF routes to special register space
`timescale 1ns/1ps
`default_nettype none
`include "mem_space_params.svh"
module cpu_memory_space_decoder
  import mem_space_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // part strap and flash write enable
  input  wire logic        is_16k_i,
  input  wire logic        flash_write_en_i,
  // program space request
  input  wire logic [15:0] code_addr_i,
  output logic             code_sel_flash_o,
  output logic             code_sel_lock_o,
  output logic             code_sel_reserved_o,
  // internal data request
  input  wire logic        iram_req_i,
  input  wire iram_req_t   iram_i,
  input  wire logic [7:0]  sfr_page_i,
  input  wire logic [7:0]  sfr_rdata_i,
  output logic             sfr_req_o,
  output logic [7:0]       sfr_addr_o,
  output logic [7:0]       iram_rdata_o,
  // indirect access through index register
  input  wire logic        indir_req_i,
  input  wire logic        indir_sel_one_i,
  // stack operations
  input  wire logic        push_i,
  input  wire logic        pop_i,
  input  wire logic [7:0]  stack_wdata_i,
  output logic [7:0]       stack_rdata_o,
  // external data request
  input  wire logic        xdata_req_i,
  input  wire xdata_req_t  xdata_i,
  output logic [15:0]      xdata_addr_o,
  output logic [7:0]       xdata_rdata_o,
  output logic             flash_write_o,
  // visible state
  output logic [7:0]       stack_pointer_o,
  output logic [1:0]       bank_o
);

  // internal ram: 256 bytes; the upper half is separate from sfr space
  logic [7:0] iram_q [256];
  logic [7:0] onchip_external_ram_q [1024];

  logic [7:0]  stack_pointer_q, stack_pointer_d;
  logic [7:0]  program_status_word_q, program_status_word_d;
  logic [7:0]  data_pointer_upper_q, data_pointer_upper_d;
  logic [7:0]  data_pointer_lower_q, data_pointer_lower_d;
  logic [7:0]  onchip_external_ram_page_select_q, onchip_external_ram_page_select_d;
  logic [7:0]  iram_rdata_q, iram_rdata_d;
  logic [7:0]  stack_rdata_q, stack_rdata_d;
  logic [7:0]  xdata_rdata_q, xdata_rdata_d;
  logic [15:0] xdata_addr_q, xdata_addr_d;
  logic        flash_write_q, flash_write_d;

  logic [1:0]  bank;
  logic [7:0]  index_ptr;
  logic [7:0]  ram_addr;
  logic [2:0]  bit_pos;
  logic        is_ram;
  logic [15:0] x_addr;
  logic [9:0]  x_index;
  logic [7:0]  push_addr;
  data_sel_t   dsel;
  code_sel_t   csel;

  // base of working register n in the active bank
  function automatic logic [7:0] reg_addr(input logic [1:0] b,
                                          input logic [2:0] n);
    reg_addr = {3'b000, b, n};
  endfunction : reg_addr

  // bit address -> byte address inside the bit area
  function automatic logic [7:0] bit_byte(input logic [7:0] a);
    bit_byte = `BIT_AREA_BASE + {4'h0, a[6:3]};
  endfunction : bit_byte

  // program space decode
  always_comb begin
    if (!is_16k_i) begin
      if (code_addr_i == `LOCK_BYTE_8K)
        csel = CS_LOCK;
      else if (code_addr_i <= `FLASH_END_8K)
        csel = CS_FLASH;
      else
        csel = CS_RESERVED;
    end else begin
      if (code_addr_i == `LOCK_BYTE_16K)
        csel = CS_LOCK;
      else if (code_addr_i > `LOCK_BYTE_16K)
        csel = CS_RESERVED;
      else
        csel = CS_FLASH;
    end
  end
  assign code_sel_flash_o    = (csel == CS_FLASH);
  assign code_sel_lock_o     = (csel == CS_LOCK);
  assign code_sel_reserved_o = (csel == CS_RESERVED);

  // internal data decode
  assign bank      = program_status_word_q[`STATUS_BANK_LSB +: 2];
  assign index_ptr = iram_q[reg_addr(bank, {2'b00, indir_sel_one_i})];
  assign bit_pos   = iram_i.addr[2:0];

  always_comb begin
    ram_addr = iram_i.addr;
    dsel     = DS_NONE;
    if (indir_req_i) begin
      ram_addr = index_ptr;
      dsel     = DS_RAM;
    end else if (iram_req_i) begin
      if (iram_i.bit_op) begin
        // operand type, not address value, picks bit access
        if (iram_i.addr <= `LOWER_RAM_TOP) begin
          ram_addr = bit_byte(iram_i.addr);
          dsel     = DS_RAM;
        end else begin
          dsel = DS_SFR;
        end
      end else if (iram_i.indirect || iram_i.addr <= `LOWER_RAM_TOP) begin
        dsel = DS_RAM;
      end else begin
        dsel = DS_SFR;
      end
    end
  end
  assign is_ram = (dsel == DS_RAM);

  // core registers held here answer before the sfr bus
  logic local_sfr;
  logic page_zero;
  assign page_zero = (sfr_page_i == `SFR_PAGE_ZERO);
  always_comb begin
    local_sfr = 1'b1;
    case (iram_i.addr)
      `STACK_PTR_ADDR:   local_sfr = 1'b1;
      `STATUS_WORD_ADDR: local_sfr = 1'b1;
      `DP_UPPER_ADDR:    local_sfr = 1'b1;
      `DP_LOWER_ADDR:    local_sfr = 1'b1;
      `PAGE_SEL_ADDR:    local_sfr = page_zero;
      default:           local_sfr = 1'b0;
    endcase
  end
  assign sfr_req_o  = (dsel == DS_SFR) && !local_sfr;
  assign sfr_addr_o = iram_i.addr;

  // sfr write/read effects and stack
  assign push_addr = stack_pointer_q + 8'h01;

  always_comb begin
    logic [7:0] rd;
    logic [7:0] wv;
    rd = 8'h00;
    wv = iram_i.wdata;
    stack_pointer_d       = stack_pointer_q;
    program_status_word_d = program_status_word_q;
    data_pointer_upper_d  = data_pointer_upper_q;
    data_pointer_lower_d  = data_pointer_lower_q;
    onchip_external_ram_page_select_d    = onchip_external_ram_page_select_q;
    stack_rdata_d         = stack_rdata_q;
    if (is_ram) begin
      rd = iram_q[ram_addr];
      if (iram_i.bit_op)
        rd = {7'h00, rd[bit_pos]};
    end else if (dsel == DS_SFR) begin
      if (iram_i.bit_op) begin
        rd = 8'h00;
      end else begin
        case (iram_i.addr)
          `STACK_PTR_ADDR:   rd = stack_pointer_q;
          `STATUS_WORD_ADDR: rd = program_status_word_q;
          `DP_UPPER_ADDR:    rd = data_pointer_upper_q;
          `DP_LOWER_ADDR:    rd = data_pointer_lower_q;
          `PAGE_SEL_ADDR:    rd = page_zero ? onchip_external_ram_page_select_q : sfr_rdata_i;
          default:           rd = sfr_rdata_i;
        endcase
        if (iram_i.write && !indir_req_i) begin
          case (iram_i.addr)
            `STACK_PTR_ADDR:   stack_pointer_d       = wv;
            `STATUS_WORD_ADDR: program_status_word_d = wv;
            `DP_UPPER_ADDR:    data_pointer_upper_d  = wv;
            `DP_LOWER_ADDR:    data_pointer_lower_d  = wv;
            `PAGE_SEL_ADDR:    begin
              if (page_zero)
                onchip_external_ram_page_select_d = wv;
            end
            default: ;
          endcase
        end
      end
    end
    // stack is indirect so high pointers reach upper ram, wraps at 256
    if (push_i) begin
      stack_pointer_d = push_addr;
    end else if (pop_i) begin
      stack_rdata_d   = iram_q[stack_pointer_q];
      stack_pointer_d = stack_pointer_q - 8'h01;
    end
    iram_rdata_d = rd;
  end

  // external data decode
  always_comb begin
    if (xdata_i.use_data_pointer)
      x_addr = {data_pointer_upper_q, data_pointer_lower_q};
    else
      x_addr = {onchip_external_ram_page_select_q, index_ptr};
  end
  // upper bits ignored: ram aliases every kilobyte
  assign x_index = x_addr[`ONCHIP_EXTERNAL_RAM_ADDR_BITS-1:0];

  always_comb begin
    xdata_addr_d  = xdata_addr_q;
    xdata_rdata_d = xdata_rdata_q;
    flash_write_d = 1'b0;
    if (xdata_req_i) begin
      xdata_addr_d = x_addr;
      if (xdata_i.write && flash_write_en_i)
        flash_write_d = 1'b1;
      else if (!xdata_i.write)
        xdata_rdata_d = onchip_external_ram_q[x_index];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      stack_pointer_q       <= `STACK_PTR_RESET;
      program_status_word_q <= 8'h00;
      data_pointer_upper_q  <= 8'h00;
      data_pointer_lower_q  <= 8'h00;
      onchip_external_ram_page_select_q    <= `PAGE_SEL_RESET;
      iram_rdata_q          <= 8'h00;
      stack_rdata_q         <= 8'h00;
      xdata_rdata_q         <= 8'h00;
      xdata_addr_q          <= 16'h0000;
      flash_write_q         <= 1'b0;
    end else begin
      stack_pointer_q       <= stack_pointer_d;
      program_status_word_q <= program_status_word_d;
      data_pointer_upper_q  <= data_pointer_upper_d;
      data_pointer_lower_q  <= data_pointer_lower_d;
      onchip_external_ram_page_select_q    <= onchip_external_ram_page_select_d;
      iram_rdata_q          <= iram_rdata_d;
      stack_rdata_q         <= stack_rdata_d;
      xdata_rdata_q         <= xdata_rdata_d;
      xdata_addr_q          <= xdata_addr_d;
      flash_write_q         <= flash_write_d;
    end
  end

  // memory arrays are not reset; contents are undefined at power-up
  always_ff @(posedge ref_clk_i) begin
    if (push_i)
      iram_q[push_addr] <= stack_wdata_i;
    else if (is_ram && iram_i.write) begin
      if (iram_i.bit_op)
        iram_q[ram_addr][bit_pos] <= iram_i.wdata[0];
      else
        iram_q[ram_addr] <= iram_i.wdata;
    end
    if (xdata_req_i && xdata_i.write && !flash_write_en_i)
      onchip_external_ram_q[x_index] <= xdata_i.wdata;
  end

  assign iram_rdata_o    = iram_rdata_q;
  assign stack_rdata_o   = stack_rdata_q;
  assign xdata_rdata_o   = xdata_rdata_q;
  assign xdata_addr_o    = xdata_addr_q;
  assign flash_write_o   = flash_write_q;
  assign stack_pointer_o = stack_pointer_q;
  assign bank_o          = bank;

endmodule : cpu_memory_space_decoder
`default_nettype wire

/* File: dv/sfr_bus_model.sv */
// far-side special register bus responder
`timescale 1ns/1ps
`default_nettype none
module sfr_bus_model (
  input  wire logic       ref_clk_i,
  input  wire logic       req_i,
  input  wire logic [7:0] addr_i,
  output logic [7:0]      rdata_o
);
  logic [7:0] junk_q = 8'h00;
  // idle bus wanders so a stale value never matches by luck
  always_ff @(posedge ref_clk_i) junk_q <= junk_q + 8'h3b;
  assign rdata_o = req_i ? ~addr_i : junk_q;
endmodule : sfr_bus_model
`default_nettype wire

/* File: dv/cpu_memory_space_decoder_asserts.sv */
// port checker for the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_space_decoder_asserts
  import mem_space_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        is_16k_i,
  input wire logic        flash_write_en_i,
  input wire logic [15:0] code_addr_i,
  input wire logic        code_sel_flash_o,
  input wire logic        code_sel_lock_o,
  input wire logic        code_sel_reserved_o,
  input wire logic        iram_req_i,
  input wire iram_req_t   iram_i,
  input wire logic        indir_req_i,
  input wire logic        sfr_req_o,
  input wire logic        push_i,
  input wire logic        pop_i,
  input wire logic        xdata_req_i,
  input wire xdata_req_t  xdata_i,
  input wire logic        flash_write_o,
  input wire logic [7:0]  stack_pointer_o,
  input wire logic [1:0]  bank_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dir, loc;
  assign dir = iram_req_i && !iram_i.indirect && !indir_req_i;
  assign loc = iram_i.addr inside {8'h81, 8'h82, 8'h83, 8'hd0, 8'haa};
  property p_code_flash;
    code_addr_i < (is_16k_i ? 16'h3bff : 16'h1fff) |-> code_sel_flash_o;
  endproperty
  a_code_flash: assert property (p_code_flash)
    else $error("low program address not flash");
  property p_code_lock;
    is_16k_i && code_addr_i == 16'h3bff |-> code_sel_lock_o;
  endproperty
  a_code_lock: assert property (p_code_lock)
    else $error("lock byte not decoded");
  property p_code_rsv;
    is_16k_i && code_addr_i > 16'h3bff |-> code_sel_reserved_o;
  endproperty
  a_code_rsv: assert property (p_code_rsv)
    else $error("upper program space not reserved");
  property p_push_ptr;
    push_i |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01;
  endproperty
  a_push_ptr: assert property (p_push_ptr)
    else $error("push did not step stack pointer");
  property p_sfr_dir;
    dir && !iram_i.bit_op && iram_i.addr[7] && !loc |-> sfr_req_o;
  endproperty
  a_sfr_dir: assert property (p_sfr_dir)
    else $error("direct upper access not forwarded");
  property p_sfr_ind;
    iram_req_i && iram_i.indirect |-> !sfr_req_o;
  endproperty
  a_sfr_ind: assert property (p_sfr_ind)
    else $error("indirect access reached special bus");
  property p_bank;
    dir && iram_i.write && !iram_i.bit_op && iram_i.addr == 8'hd0
      && !push_i |=> bank_o == $past(iram_i.wdata[4:3]);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank select not taken from status bits");
  property p_flash_wr;
    xdata_req_i && xdata_i.write && flash_write_en_i |=> flash_write_o;
  endproperty
  a_flash_wr: assert property (p_flash_wr)
    else $error("enabled write not steered to flash");
  property p_no_flash;
    xdata_req_i && !flash_write_en_i |=> !flash_write_o;
  endproperty
  a_no_flash: assert property (p_no_flash)
    else $error("external move reached flash");
endmodule : cpu_memory_space_decoder_asserts
bind cpu_memory_space_decoder cpu_memory_space_decoder_asserts i_asserts (
  .ref_clk_i, .rst_n_i, .is_16k_i, .flash_write_en_i, .code_addr_i,
  .code_sel_flash_o, .code_sel_lock_o, .code_sel_reserved_o, .iram_req_i,
  .iram_i, .indir_req_i, .sfr_req_o, .push_i, .pop_i, .xdata_req_i,
  .xdata_i, .flash_write_o, .stack_pointer_o, .bank_o);
`default_nettype wire

/* File: dv/cpu_memory_space_decoder_tb.sv */
// self-checking bench for the memory space decoder
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_space_decoder_tb;
  import mem_space_pkg::*;
  logic        ref_clk_i = 0, rst_n_i = 0, is_16k_i = 1, fwe = 0;
  logic [15:0] code_addr_i = 16'h0000, xa_o;
  logic        iram_req_i = 0, indir_req_i = 0, sel1 = 0, sfr_req_o, sfr_seen;
  iram_req_t   iram_i = '0;
  xdata_req_t  xdata_i = '0;
  logic [7:0]  sfr_page_i = 8'h00, sfr_rd, sfr_a, rd, sd = 8'h00, s_rd, x_rd;
  logic [7:0]  stk_ptr;
  logic        push_i = 0, pop_i = 0, xdata_req_i = 0, fl, lk, rs, fw;
  logic [1:0]  bank_o;
  int          fails = 0, cmp_count = 0, cyc = 0;
  cpu_memory_space_decoder i_cpu_memory_space_decoder (.ref_clk_i,
    .rst_n_i, .is_16k_i, .flash_write_en_i(fwe), .code_addr_i,
    .code_sel_flash_o(fl), .code_sel_lock_o(lk), .code_sel_reserved_o(rs),
    .iram_req_i, .iram_i, .sfr_page_i, .sfr_rdata_i(sfr_rd), .sfr_req_o,
    .sfr_addr_o(sfr_a), .iram_rdata_o(rd), .indir_req_i,
    .indir_sel_one_i(sel1), .push_i, .pop_i, .stack_wdata_i(sd),
    .stack_rdata_o(s_rd), .xdata_req_i, .xdata_i, .xdata_addr_o(xa_o),
    .xdata_rdata_o(x_rd), .flash_write_o(fw), .stack_pointer_o(stk_ptr),
    .bank_o);
  sfr_bus_model i_sfr_bus_model (.ref_clk_i, .req_i(sfr_req_o),
    .addr_i(sfr_a), .rdata_o(sfr_rd));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one access, request up for exactly one taking edge
  task automatic ia(input logic [7:0] a, input logic ind, b, w, ir,
                    input logic [7:0] d);
    @(negedge ref_clk_i);
    iram_req_i = 1'b1;
    indir_req_i = ir;
    iram_i = '{a, ind, b, w, d};
    #1 sfr_seen = sfr_req_o;
    @(negedge ref_clk_i);
    iram_req_i = 1'b0;
    indir_req_i = 1'b0;
  endtask : ia
  task automatic sop(input logic pu, po, input logic [7:0] d);
    @(negedge ref_clk_i);
    {push_i, pop_i, sd} = {pu, po, d};
    @(negedge ref_clk_i);
    {push_i, pop_i} = 2'b00;
  endtask : sop
  task automatic xop(input logic u, w, input logic [7:0] d);
    @(negedge ref_clk_i);
    xdata_req_i = 1'b1;
    xdata_i = '{u, w, d};
    @(negedge ref_clk_i);
    xdata_req_i = 1'b0;
  endtask : xop
  task automatic t_code;
    logic [15:0] al [5] = '{16'h0000, 16'h1fff, 16'h3bfe, 16'h3bff, 16'hffff};
    logic [15:0] lim;
    logic [2:0]  ex;
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 5; i++) begin
        @(negedge ref_clk_i);
        is_16k_i = k[0];
        code_addr_i = al[i];
        lim = k ? 16'h3bff : 16'h1fff;
        ex = {al[i] < lim, al[i] == lim, al[i] > lim};
        #1;
        if (k == 1 || al[i] <= 16'h1fff)
          chk({fl, lk, rs}, ex);
      end
    end
    $display("test code map done");
  endtask : t_code
  task automatic t_stack;
    chk(stk_ptr, 8'h07);
    sop(1'b1, 1'b0, 8'hc3);
    chk(stk_ptr, 8'h08);
    ia(8'h08, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(rd, 8'hc3);
    // a push above 0x7f must land in upper ram, not special registers
    ia(8'h81, 1'b0, 1'b0, 1'b1, 1'b0, 8'h8f);
    sop(1'b1, 1'b0, 8'h4d);
    chk(stk_ptr, 8'h90);
    ia(8'h90, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(rd, 8'h4d);
    ia(8'h81, 1'b0, 1'b0, 1'b1, 1'b0, 8'hff);
    sop(1'b1, 1'b0, 8'h9e);
    chk(stk_ptr, 8'h00);
    sop(1'b0, 1'b1, 8'h00);
    chk(s_rd, 8'h9e);
    chk(stk_ptr, 8'hff);
    $display("test stack done");
  endtask : t_stack
  task automatic t_banks;
    ia(8'h90, 1'b1, 1'b0, 1'b1, 1'b0, 8'h5a);
    chk(sfr_seen, 1'b0);
    ia(8'hd0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h18);
    chk(bank_o, 2'b11);
    ia(8'h18, 1'b0, 1'b0, 1'b1, 1'b0, 8'h90);
    ia(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    chk(rd, 8'h5a);
    ia(8'h90, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk({sfr_seen, rd}, {1'b1, 8'h6f});
    ia(8'h7f, 1'b1, 1'b0, 1'b1, 1'b0, 8'h3c);
    ia(8'h7f, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(rd, 8'h3c);
    // index reg one of bank 3 points back at 0x7f
    ia(8'h19, 1'b0, 1'b0, 1'b1, 1'b0, 8'h7f);
    sel1 = 1'b1;
    ia(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    sel1 = 1'b0;
    chk(rd, 8'h3c);
    ia(8'hd0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    $display("test banks done");
  endtask : t_banks
  task automatic t_bits;
    ia(8'h22, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    ia(8'h13, 1'b0, 1'b1, 1'b1, 1'b0, 8'h01);
    ia(8'h22, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(rd, 8'h08);
    ia(8'h13, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00);
    chk(rd[0], 1'b1);
    $display("test bits done");
  endtask : t_bits
  task automatic t_xdata;
    ia(8'h83, 1'b0, 1'b0, 1'b1, 1'b0, 8'h12);
    ia(8'h82, 1'b0, 1'b0, 1'b1, 1'b0, 8'h34);
    xop(1'b1, 1'b1, 8'ha5);
    chk({xa_o, fw}, {16'h1234, 1'b0});
    ia(8'haa, 1'b0, 1'b0, 1'b1, 1'b0, 8'h12);
    sfr_page_i = 8'h0f;
    ia(8'haa, 1'b0, 1'b0, 1'b1, 1'b0, 8'h77);
    sfr_page_i = 8'h00;
    ia(8'haa, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(rd, 8'h12);
    ia(8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 8'h34);
    xop(1'b0, 1'b0, 8'h00);
    chk({xa_o, x_rd}, {16'h1234, 8'ha5});
    fwe = 1'b1;
    xop(1'b1, 1'b1, 8'h00);
    chk(fw, 1'b1);
    fwe = 1'b0;
    $display("test external data done");
  endtask : t_xdata
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    ia(8'haa, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    chk(rd, 8'h00);
    t_code();
    t_stack();
    t_banks();
    t_bits();
    t_xdata();
    conclude();
  end
endmodule : cpu_memory_space_decoder_tb
`default_nettype wire
